//--- dwl_ctrl.sv
// Wiper transfer hold and per channel shutdown control top
`timescale 1ns/100ps
module dwl_ctrl
  import dwl_pkg::*;
#(
  parameter int WIDTH = DATA_WIDTH,
  parameter int NCH = CHANNELS,
  parameter int DELAY_CYCLES = ENTRY_DELAY_CYCLES
)
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Hold pin, asynchronous, high blocks transfers
  input wire logic wiper_transfer_hold,
  // Serial command strobes, one cycle, from the slave port
  input wire logic write_strobe,
  input wire logic [NCH-1:0] write_data_sel,
  input wire logic [WIDTH-1:0] write_data,
  input wire logic write_shut_strobe,
  input wire logic [2*NCH-1:0] write_shut_data,
  input wire logic read_shut_strobe,
  input wire logic general_reset,
  input wire logic general_wakeup,
  // Nonvolatile shadow values
  input wire logic [NCH*WIDTH-1:0] shadow_data,
  input wire logic [2*NCH-1:0] shadow_shut,
  input wire logic [2*NCH-1:0] channel_reference_sel,
  // Outputs
  output logic [NCH*WIDTH-1:0] dac_register,
  output logic [NCH*WIDTH-1:0] wiper,
  output logic [2*NCH-1:0] channel_shutdown_sel,
  output dwl_pkg::dwl_enables_type [NCH-1:0] channel_enables
);
  import dwl_pkg::*;

  initial
  begin
    if (NCH < 1 || NCH > 2 || WIDTH < 1 || WIDTH > DATA_WIDTH)
    begin
      $error("Unsupported channel count or width");
    end
  end

  // ****************************************************************************
  // Hold synchroniser
  // ****************************************************************************
  // Only hold_sync may be read; hold_meta can still be settling
  logic hold_meta;
  logic hold_sync;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // Reset to held so no wiper moves until the pin is seen
      hold_meta <= 1'b1;
      hold_sync <= 1'b1;
    end
    else if (clk_en)
    begin
      hold_meta <= wiper_transfer_hold;
      hold_sync <= hold_meta;
    end
  end

  // ****************************************************************************
  // Volatile registers and wipers
  // ****************************************************************************
  logic load_shadow;
  logic post_reset;
  assign load_shadow = general_reset || post_reset;

  // First enabled edge after reset loads shadow values
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      post_reset <= 1'b1;
    else if (clk_en)
      post_reset <= 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dac_register <= {NCH{DATA_RESET[WIDTH-1:0]}};
    end
    else if (clk_en)
    begin
      if (load_shadow)
        dac_register <= shadow_data;
      else
      begin
        for (int i = 0; i < NCH; i++)
        begin
          // Writes land regardless of hold
          if (write_strobe && write_data_sel[i])
            dac_register[i*WIDTH +: WIDTH] <= write_data;
        end
      end
    end
  end

  // All channels share one hold, so a falling hold loads both at once
  // Limitation: a hold pulse shorter than one clock may never be seen
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wiper <= {NCH{DATA_RESET[WIDTH-1:0]}};
    else if (clk_en && !hold_sync)
      wiper <= dac_register;
  end

  // ****************************************************************************
  // Shutdown selection, one field per channel
  // ****************************************************************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      channel_shutdown_sel <= {NCH{SHUT_RESET}};
    else if (clk_en)
    begin
      // Serial side is never gated by shutdown
      if (load_shadow)
        channel_shutdown_sel <= shadow_shut;
      else if (general_wakeup)
        channel_shutdown_sel <= {NCH{SHUT_NORMAL}};
      else if (write_shut_strobe || read_shut_strobe)
        channel_shutdown_sel <= write_shut_data;
    end
  end

  for (genvar g = 0; g < NCH; g++)
  begin : gen_chan
    dwl_shutdown_chan #(
      .DELAY_CYCLES(DELAY_CYCLES)
    ) u_chan (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .shut_sel(channel_shutdown_sel[2*g +: 2]),
      .ref_sel(channel_reference_sel[2*g +: 2]),
      .enables(channel_enables[g])
    );
  end

  // ****************************************************************************
  // Checks
  // ****************************************************************************
  property p_hold_blocks;
    @(posedge clk) disable iff (!reset_n)
    (hold_sync && clk_en) |=> $stable(wiper);
  endproperty
  a_hold_blocks: assert property (p_hold_blocks) else $error("Wiper moved while held");

  property p_follow;
    @(posedge clk) disable iff (!reset_n)
    (!hold_sync && clk_en) |=> wiper == $past(dac_register);
  endproperty
  a_follow: assert property (p_follow) else $error("Wiper did not follow register");

  property p_write_lands;
    @(posedge clk) disable iff (!reset_n)
    (clk_en && write_strobe && write_data_sel[0] && !load_shadow) |=> dac_register[WIDTH-1:0] == $past(write_data);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("Write lost");

  property p_sync_delay;
    @(posedge clk) disable iff (!reset_n)
    (clk_en && !wiper_transfer_hold) ##1 clk_en |=> !hold_sync;
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("Synchroniser depth wrong");

  property p_hold_sync_high;
    @(posedge clk) disable iff (!reset_n)
    (clk_en && wiper_transfer_hold) ##1 clk_en |=> hold_sync;
  endproperty
  a_hold_sync_high: assert property (p_hold_sync_high) else $error("Hold rise not seen after two edges");

  property p_wakeup;
    @(posedge clk) disable iff (!reset_n)
    (clk_en && general_wakeup && !load_shadow) |=> channel_shutdown_sel == '0;
  endproperty
  a_wakeup: assert property (p_wakeup) else $error("Wake-up did not clear shutdown");

  property p_greset;
    @(posedge clk) disable iff (!reset_n)
    (clk_en && general_reset) |=> dac_register == $past(shadow_data) && channel_shutdown_sel == $past(shadow_shut);
  endproperty
  a_greset: assert property (p_greset) else $error("General reset did not load shadow");

  property p_power_on_load;
    @(posedge clk) disable iff (!reset_n)
    (clk_en && post_reset) |=> dac_register == $past(shadow_data) && channel_shutdown_sel == $past(shadow_shut);
  endproperty
  a_power_on_load: assert property (p_power_on_load) else $error("Power-on load missed");

  property p_read_update;
    @(posedge clk) disable iff (!reset_n)
    (clk_en && read_shut_strobe && !load_shadow && !general_wakeup)
      |=> channel_shutdown_sel == $past(write_shut_data);
  endproperty
  a_read_update: assert property (p_read_update) else $error("Read command did not update shutdown");

  property p_shut_stable;
    @(posedge clk) disable iff (!reset_n)
    (clk_en && !load_shadow && !general_wakeup && !write_shut_strobe && !read_shut_strobe)
      |=> $stable(channel_shutdown_sel);
  endproperty
  a_shut_stable: assert property (p_shut_stable) else $error("Shutdown bits changed without cause");

  property p_amp_normal;
    @(posedge clk) disable iff (!reset_n)
    (clk_en && channel_shutdown_sel[1:0] == SHUT_NORMAL) ##1 clk_en |=> channel_enables[0].amp;
  endproperty
  a_amp_normal: assert property (p_amp_normal) else $error("Amplifier off in normal mode");

  property p_freeze;
    @(posedge clk) disable iff (!reset_n)
    !clk_en |=> $stable(dac_register) && $stable(wiper) && $stable(channel_shutdown_sel)
      && $stable(channel_enables);
  endproperty
  a_freeze: assert property (p_freeze) else $error("State moved while clock enable low");

  c_hold_release: cover property (@(posedge clk) disable iff (!reset_n) hold_sync ##1 !hold_sync);
  c_write_held: cover property (@(posedge clk) disable iff (!reset_n) hold_sync && write_strobe);
  c_shut_enter: cover property (@(posedge clk) disable iff (!reset_n) channel_enables[0].pull_1k);
  c_wakeup: cover property (@(posedge clk) disable iff (!reset_n) general_wakeup);
  c_both_open: cover property (@(posedge clk) disable iff (!reset_n) channel_shutdown_sel == {NCH{SHUT_OPEN}});

  // ****************************************************************************
  // Per channel checks
  // ****************************************************************************
  // Check-only helper logic; nothing in the datapath reads it
  localparam int ECW = $clog2(DELAY_CYCLES + 3);

  for (genvar c = 0; c < NCH; c++)
  begin : gen_chk
    logic [ECW-1:0] entry_count;

    // Enabled edges seen with a shutdown code selected, saturating two past the delay
    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
        entry_count <= '0;
      else if (clk_en)
      begin
        if (channel_shutdown_sel[2*c +: 2] == SHUT_NORMAL)
          entry_count <= '0;
        else if (entry_count != ECW'(DELAY_CYCLES + 2))
          entry_count <= entry_count + 1'b1;
      end
    end

    property p_chan_write;
      @(posedge clk) disable iff (!reset_n)
      (clk_en && write_strobe && write_data_sel[c] && !load_shadow)
        |=> dac_register[c*WIDTH +: WIDTH] == $past(write_data);
    endproperty
    a_chan_write: assert property (p_chan_write) else $error("Channel write lost");

    property p_chan_keep;
      @(posedge clk) disable iff (!reset_n)
      (clk_en && !load_shadow && !(write_strobe && write_data_sel[c]))
        |=> $stable(dac_register[c*WIDTH +: WIDTH]);
    endproperty
    a_chan_keep: assert property (p_chan_keep) else $error("Register changed without a write");

    property p_chan_field;
      @(posedge clk) disable iff (!reset_n)
      (clk_en && !load_shadow && !general_wakeup && (write_shut_strobe || read_shut_strobe))
        |=> channel_shutdown_sel[2*c +: 2] == $past(write_shut_data[2*c +: 2]);
    endproperty
    a_chan_field: assert property (p_chan_field) else $error("Shutdown field not loaded");

    property p_chan_bandgap;
      @(posedge clk) disable iff (!reset_n)
      clk_en |=> channel_enables[c].bandgap == ($past(channel_reference_sel[2*c +: 2]) == REF_BANDGAP);
    endproperty
    a_chan_bandgap: assert property (p_chan_bandgap) else $error("Band gap enable wrong");

    // Output keeps driving through the whole entry delay
    property p_entry_driving;
      @(posedge clk) disable iff (!reset_n)
      (entry_count != '0 && entry_count <= ECW'(DELAY_CYCLES)) |-> channel_enables[c].amp;
    endproperty
    a_entry_driving: assert property (p_entry_driving) else $error("Output stopped before entry delay");

    property p_entry_done;
      @(posedge clk) disable iff (!reset_n)
      (entry_count == ECW'(DELAY_CYCLES + 2)) |-> !channel_enables[c].amp;
    endproperty
    a_entry_done: assert property (p_entry_done) else $error("Output still driven after entry delay");
  end

endmodule : dwl_ctrl

//--- dwl_pkg.sv
// Package of constants and types for the wiper transfer and shutdown control
// ****************************************************************************
// ****************************************************************************
package dwl_pkg;

  // ****************************************************************************
  // Sizes and codes
  // ****************************************************************************
  localparam int DATA_WIDTH = 12;
  localparam int CHANNELS = 2;
  localparam logic [1:0] SHUT_NORMAL = 2'h0;
  localparam logic [1:0] SHUT_PULL_1K = 2'h1;
  localparam logic [1:0] SHUT_PULL_100K = 2'h2;
  localparam logic [1:0] SHUT_OPEN = 2'h3;
  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [1:0] REF_BANDGAP = 2'h1;
  localparam logic [1:0] REF_PIN_UNBUF = 2'h2;
  localparam logic [1:0] REF_PIN_BUF = 2'h3;
  localparam logic [1:0] SHUT_RESET = 2'h0;
  localparam logic [DATA_WIDTH-1:0] DATA_RESET = 12'h000;

  // ****************************************************************************
  // Timing
  // ****************************************************************************
  localparam int CLK_PERIOD_PS = 4000;
  localparam int ENTRY_DELAY_NS = 10000;
  localparam int ENTRY_DELAY_CYCLES = (ENTRY_DELAY_NS * 1000) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {DWL_DRIVE, DWL_ENTERING, DWL_SHUT} dwl_state_type;

  // Decoded per channel enables
  typedef struct packed {
    logic amp;
    logic ladder;
    logic ref_buffer;
    logic bandgap;
    logic pull_1k;
    logic pull_100k;
  } dwl_enables_type;

  function automatic dwl_enables_type dwl_decode(input logic [1:0] shut, input logic [1:0] refsel,
                                                 input logic active);
    dwl_enables_type e;
    e = '0;
    e.amp = active;
    e.ladder = active && (refsel != REF_PIN_UNBUF);
    e.ref_buffer = active && (refsel == REF_BANDGAP || refsel == REF_PIN_BUF);
    e.bandgap = (refsel == REF_BANDGAP);
    e.pull_1k = !active && (shut == SHUT_PULL_1K);
    e.pull_100k = !active && (shut == SHUT_PULL_100K);
    return e;
  endfunction : dwl_decode

endpackage : dwl_pkg

//--- dwl_shutdown_chan.sv
// One channel of shutdown sequencing: entry delay and circuit enables
`timescale 1ns/100ps
module dwl_shutdown_chan
  import dwl_pkg::*;
#(
  parameter int DELAY_CYCLES = ENTRY_DELAY_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Selection
  input wire logic [1:0] shut_sel,
  input wire logic [1:0] ref_sel,
  // Enables
  output dwl_pkg::dwl_enables_type enables
);
  import dwl_pkg::*;

  initial
  begin
    if (DELAY_CYCLES < 1)
    begin
      $error("Entry delay must be at least one cycle");
    end
  end

  localparam int CW = $clog2(DELAY_CYCLES + 1);
  dwl_state_type state;
  logic [CW-1:0] count;

  // ****************************************************************************
  // Entry delay: output keeps driving until the count expires
  // ****************************************************************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= DWL_DRIVE;
      count <= '0;
    end
    else if (clk_en)
    begin
      unique case (state)
        DWL_DRIVE:
        begin
          if (shut_sel != SHUT_NORMAL)
          begin
            state <= DWL_ENTERING;
            count <= CW'(DELAY_CYCLES - 1);
          end
        end
        DWL_ENTERING:
        begin
          if (shut_sel == SHUT_NORMAL)
            state <= DWL_DRIVE;
          else if (count == '0)
            state <= DWL_SHUT;
          else
            count <= count - 1'b1;
        end
        DWL_SHUT:
        begin
          if (shut_sel == SHUT_NORMAL)
            state <= DWL_DRIVE;
        end
        default: state <= DWL_DRIVE;
      endcase
    end
  end

  // Registered so the top drives straight from flops
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      enables <= '0;
    else if (clk_en)
      // Keeps driving until the delay has run out, and at once when normal is chosen again
      enables <= dwl_decode(shut_sel, ref_sel, state != DWL_SHUT || shut_sel == SHUT_NORMAL);
  end

  property p_entry_delay;
    @(posedge clk) disable iff (!reset_n)
    (state == DWL_DRIVE && clk_en && shut_sel != SHUT_NORMAL) |=> state == DWL_ENTERING;
  endproperty
  a_entry_delay: assert property (p_entry_delay) else $error("Entry delay not started");

  property p_amp_off_in_shut;
    @(posedge clk) disable iff (!reset_n)
    (state == DWL_SHUT && clk_en && shut_sel != SHUT_NORMAL) |=> !enables.amp;
  endproperty
  a_amp_off_in_shut: assert property (p_amp_off_in_shut) else $error("Amplifier on in shutdown");

endmodule : dwl_shutdown_chan

//--- dwl_host.sv
// Host model: slave port command strobes and the transfer hold pin
`timescale 1ns/100ps
module dwl_host
  import dwl_pkg::*;
(
  // Clock
  input wire logic clk,
  // Hold pin and command strobes
  output logic hold,
  output logic ws,
  output logic [CHANNELS-1:0] sel,
  output logic [DATA_WIDTH-1:0] data,
  output logic wss,
  output logic rss,
  output logic [2*CHANNELS-1:0] sdata,
  output logic grst,
  output logic gwake
);
  // ********************
  // Host actions
  // ********************
  // Hold starts high; a host without synchronised updates would tie it low
  // No nonvolatile store is ever issued, so none happens while both are shut
  initial
  begin
    {ws, sel, data, wss, rss, sdata, grst, gwake} = '0;
    hold = 1'b1;
  end

  // Kind: 0 data write, 1 shutdown write, 2 read, 3 general reset, 4 wake-up
  task automatic cmd(input int k, input logic [1:0] s, input logic [11:0] d, input logic [3:0] p);
    @(posedge clk);
    ws <= (k == 0);
    wss <= (k == 1);
    rss <= (k == 2);
    grst <= (k == 3);
    gwake <= (k == 4);
    sel <= s;
    data <= d;
    sdata <= p;
    @(posedge clk);
    {ws, wss, rss, grst, gwake} <= '0;
  endtask : cmd

  task automatic set_hold(input logic v);
    @(posedge clk);
    hold <= v;
  endtask : set_hold
endmodule : dwl_host

//--- testbench.sv
// Self-checking bench for the wiper transfer and shutdown control
`timescale 1ns/100ps
module testbench;
  import dwl_pkg::*;
  localparam int DLY = 4;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hold, ws, wss, rss, grst, gwake;
  logic [1:0] sel, cs;
  logic clk_en = 1'b1;
  logic [11:0] wd, d;
  logic [3:0] sdata, shut, ref_sel, sh_shut;
  logic [23:0] sh_data, dac, wip, exp_dac;
  dwl_enables_type [1:0] en;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n;

  always #2 clk = ~clk;

  dwl_host u_dwl_host (.clk(clk), .hold(hold), .ws(ws), .sel(sel), .data(wd), .wss(wss), .rss(rss),
    .sdata(sdata), .grst(grst), .gwake(gwake));
  dwl_ctrl #(.DELAY_CYCLES(DLY)) u_dwl_ctrl (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .wiper_transfer_hold(hold), .write_strobe(ws), .write_data_sel(sel), .write_data(wd),
    .write_shut_strobe(wss), .write_shut_data(sdata), .read_shut_strobe(rss), .general_reset(grst),
    .general_wakeup(gwake), .shadow_data(sh_data), .shadow_shut(sh_shut), .channel_reference_sel(ref_sel),
    .dac_register(dac), .wiper(wip), .channel_shutdown_sel(shut), .channel_enables(en));

  // ********************
  // Helpers
  // ********************
  function automatic dwl_enables_type exp_en(input logic [1:0] s, input logic [1:0] r);
    dwl_enables_type e;
    e.amp = (s == 2'h0);
    e.ladder = e.amp && (r != 2'h2);
    e.ref_buffer = e.amp && r[0];
    e.bandgap = (r == 2'h1);
    e.pull_1k = (s == 2'h1);
    e.pull_100k = (s == 2'h2);
    return e;
  endfunction : exp_en

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Counts edges until the wiper shows the expected value, at most eight
  task automatic wait_wiper(output int k);
    k = 0;
    #1;
    while (wip !== exp_dac && k < 8)
    begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask : wait_wiper

  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      print_verdict();
    end
  end

  // ********************
  // Tests
  // ********************
  initial
  begin
    void'($urandom(32'hb301deda));
    sh_data = 24'($urandom);
    sh_shut = 4'h0;
    ref_sel = 4'($urandom);
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(dac, sh_data);
    check(24'(shut), 24'(sh_shut));
    check(wip, 24'h0);
    exp_dac = sh_data;
    for (int s = 1; s < 4; s++)
    begin
      d = 12'($urandom);
      u_dwl_host.cmd(0, 2'(s), d, 4'h0);
      for (int c = 0; c < 2; c++)
        if (s[c])
          exp_dac[c*12 +: 12] = d;
      #1;
      check(dac, exp_dac);
      check(wip, 24'h0);
    end
    u_dwl_host.set_hold(1'b0);
    wait_wiper(n);
    check(wip, exp_dac);
    check(24'(n), 24'h3);
    $display("Held transfer test done");
    repeat (8)
    begin
      cs = 2'($urandom_range(3, 1));
      d = 12'($urandom);
      u_dwl_host.cmd(0, cs, d, 4'h0);
      for (int c = 0; c < 2; c++)
        if (cs[c])
          exp_dac[c*12 +: 12] = d;
      wait_wiper(n);
      check(wip, exp_dac);
      check(24'(n), 24'h1);
    end
    $display("Follow test done");
    @(posedge clk);
    clk_en <= 1'b0;
    d = 12'($urandom);
    u_dwl_host.cmd(0, 2'h3, d, 4'h0);
    #1;
    check(dac, exp_dac);
    check(wip, exp_dac);
    @(posedge clk);
    clk_en <= 1'b1;
    $display("Clock enable freeze test done");
    for (int s = 1; s < 4; s++)
    begin
      @(posedge clk);
      ref_sel <= 4'($urandom);
      u_dwl_host.cmd(1, 2'h0, 12'h0, {2'h0, 2'(s)});
      #1;
      check(24'(shut), 24'({2'h0, 2'(s)}));
      check(24'(en[0].amp), 24'h1);
      repeat (DLY) @(posedge clk);
      #1;
      check(24'(en[0].amp), 24'h1);
      repeat (4) @(posedge clk);
      #1;
      check(24'(en), 24'({exp_en(2'h0, ref_sel[3:2]), exp_en(2'(s), ref_sel[1:0])}));
      check(24'(en[1].amp), 24'h1);
      check(dac, exp_dac);
      u_dwl_host.cmd(2, 2'h0, 12'h0, 4'h0);
      repeat (2) @(posedge clk);
      #1;
      check(24'(en[0]), 24'(exp_en(2'h0, ref_sel[1:0])));
    end
    $display("Shutdown code test done");
    u_dwl_host.cmd(1, 2'h0, 12'h0, 4'hf);
    d = 12'($urandom);
    u_dwl_host.cmd(0, 2'h3, d, 4'h0);
    exp_dac = {d, d};
    #1;
    check(dac, exp_dac);
    u_dwl_host.cmd(4, 2'h0, 12'h0, 4'h0);
    #1;
    check(24'(shut), 24'h0);
    @(posedge clk);
    sh_data <= 24'($urandom);
    sh_shut <= 4'($urandom);
    u_dwl_host.cmd(3, 2'h0, 12'h0, 4'h0);
    #1;
    check(dac, sh_data);
    check(24'(shut), 24'(sh_shut));
    $display("Wake and reset test done");
    print_verdict();
  end
endmodule : testbench
